// [design/hpw_regs.svh]
// Register offsets, field positions, reset values and timing counts of the fast pulse block
`ifndef HPW_REGS_SVH
`define HPW_REGS_SVH

// ----------------------------------------------------------------------
// Register indices and byte addresses (byte address = 4 x index)
// ----------------------------------------------------------------------
`define HPW_IDX_CONTROL    8'h0c
`define HPW_IDX_CH0_WIDTH  8'h0d
`define HPW_IDX_CH1_WIDTH  8'h0e
`define HPW_IDX_STATUS     8'h0f
`define HPW_ADDR_W         8

// ----------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------
`define HPW_CTL_MODE_LSB   0
`define HPW_CTL_MODE_MSB   1
`define HPW_CTL_RUN_BIT    2
`define HPW_CTL_EN0_BIT    3
`define HPW_CTL_EN1_BIT    4
`define HPW_CTL_USED_W     5

// ----------------------------------------------------------------------
// Mode codes and reset values
// ----------------------------------------------------------------------
`define HPW_MODE_8BIT      2'h0
`define HPW_MODE_7BIT      2'h1
`define HPW_MODE_6BIT      2'h2
`define HPW_RST_CONTROL    5'h00
`define HPW_RST_WIDTH      8'h10

// ----------------------------------------------------------------------
// Periods in source clocks (count wraps at period - 1)
// ----------------------------------------------------------------------
`define HPW_WRAP_8BIT      8'hff
`define HPW_WRAP_7BIT      8'h7f
`define HPW_WRAP_6BIT      8'h3f

`endif

// [design/hpw_pkg.sv]
// Types shared by the fast pulse block
package hpw_pkg;

	// ------------------------------------------------------------------
	// Counter resolution, one-hot
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		HPW_RES_8 = 3'b001,
		HPW_RES_7 = 3'b010,
		HPW_RES_6 = 3'b100
	} hpw_res_t;

	// ------------------------------------------------------------------
	// Control register contents
	// ------------------------------------------------------------------
	typedef struct packed {
		logic       ch1_output_enable;
		logic       ch0_output_enable;
		logic       counter_run;
		logic [1:0] resolution_mode;
	} hpw_ctl_t;

	// ------------------------------------------------------------------
	// Per-channel timing handed to the output stage
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [8:0] whole_clocks;
		logic       half_ext;
	} hpw_width_t;

endpackage : hpw_pkg

// [design/hpw_bus_ack.sv]
// Avalon-MM wait-state generator: one wait cycle, then accept
`timescale 1ns/1ps
module hpw_bus_ack (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic clk_en,
	// Request
	input  wire logic read,
	input  wire logic write,
	// Answer
	output logic      waitrequest,
	output logic      accept
);

	logic ack;

	// Ack goes high one edge after a request, and drops at its acceptance
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack <= 1'b0;
		end else if (clk_en) begin
			ack <= (read | write) & ~ack;
		end
	end

	// Frozen clock enable holds waitrequest high, so no access slips through
	assign waitrequest = (read | write) & ~(ack & clk_en);
	assign accept      = (read | write) & ack & clk_en;

endmodule : hpw_bus_ack

// [design/hpw_channel.sv]
// One pulse channel: width compare plus half-clock trailing extension
`timescale 1ns/1ps
module hpw_channel
	import hpw_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	// Shared counter state
	input  wire logic       counter_run,
	input  wire logic [7:0] count,
	// Channel control
	input  wire logic       output_enable,
	input  wire hpw_width_t width,
	// Pin
	output logic            pulse_out
);

	logic full_active;
	logic half_active;

	// Active phase in whole clocks, registered so the pin is glitch free
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			full_active <= 1'b0;
		end else if (clk_en) begin
			full_active <= counter_run & ({1'b0, count} < width.whole_clocks);
		end
	end

	// Falling-edge copy stretches the pulse by half a clock; duty of clock matters
	always_ff @(negedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			half_active <= 1'b0;
		end else if (clk_en) begin
			half_active <= full_active & width.half_ext;
		end
	end

	// Active-low pulse; idle or disabled pin rests high
	assign pulse_out = ~(output_enable & counter_run & (full_active | half_active));

endmodule : hpw_channel

// [design/hpw_top.sv]
// Two-channel fast pulse-width modulator with Avalon-MM register access
//
// Overview of operation
// - Two outputs, each with its own width register
// - Mode 00/01/10 selects 8/7/6-bit counting
// - Run bit stops or runs shared counter
// - Per-channel enable drives pulse onto pin
// - Stopped: counter cleared, pins held high
// - One mode setting shared by both channels
// - 8-bit: 256-clock period, width data clocks
// - 7-bit: 128 clocks, lsb adds half clock
// - 6-bit: 64 clocks, low bits dither halves
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "hpw_regs.svh"
module hpw_top
	import hpw_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	// Avalon-MM slave
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [3:0]  byteenable,
	input  wire logic [31:0] writedata,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	// Pulse pins, active low
	output logic             pulse_out_ch0,
	output logic             pulse_out_ch1
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	// Registers and their period shadows
	hpw_ctl_t   pwm_control;
	logic [7:0] pwm_ch0_width;
	logic [7:0] pwm_ch1_width;
	logic [7:0] shadow_ch0;
	logic [7:0] shadow_ch1;
	// Shared counter and dither
	logic [7:0] count;
	logic [7:0] next_count;
	logic [7:0] wrap_value;
	logic       period_end;
	logic       dither_phase;
	// Bus handshake and decode
	logic       accept;
	logic       wr_take;
	logic [5:0] word_index;
	logic       addr_aligned;
	logic       hit_control;
	logic       hit_ch0;
	logic       hit_ch1;
	logic       hit_status;
	logic       lane0;
	logic [31:0] next_readdata;
	// Resolution and per-channel timing
	hpw_res_t   resolution;
	hpw_width_t width_ch0;
	hpw_width_t width_ch1;

	// ------------------------------------------------------------------
	// Bus handshake
	// ------------------------------------------------------------------

	// Every access costs one wait cycle while clock enable is high; read data are ready by then
	// Accept marks the one cycle in which a request takes effect
	hpw_bus_ack u_bus_ack (
		.sys_clk     (sys_clk),
		.rst_n       (rst_n),
		.clk_en      (clk_en),
		.read        (read),
		.write       (write),
		.waitrequest (waitrequest),
		.accept      (accept)
	);

	// Address decode on aligned words; unmapped words read zero, writes dropped
	assign word_index   = address[7:2];
	assign addr_aligned = (address[1:0] == 2'h0);
	assign hit_control  = addr_aligned & ({2'h0, word_index} == `HPW_IDX_CONTROL);
	assign hit_ch0      = addr_aligned & ({2'h0, word_index} == `HPW_IDX_CH0_WIDTH);
	assign hit_ch1      = addr_aligned & ({2'h0, word_index} == `HPW_IDX_CH1_WIDTH);
	assign hit_status   = addr_aligned & ({2'h0, word_index} == `HPW_IDX_STATUS);
	// Lane 0 carries every writable bit, so upper lanes alone write nothing
	assign lane0        = byteenable[0];
	assign wr_take      = accept & write & lane0;

	// ------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------

	// Control register; mode is taken as written, software keeps it stable while running
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_control <= `HPW_RST_CONTROL;
		end else if (clk_en && wr_take && hit_control) begin
			pwm_control <= writedata[`HPW_CTL_USED_W-1:0];
		end
	end

	// Channel width registers, one per channel
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_ch0_width <= `HPW_RST_WIDTH;
			pwm_ch1_width <= `HPW_RST_WIDTH;
		end else if (clk_en && wr_take) begin
			if (hit_ch0) begin
				pwm_ch0_width <= writedata[7:0];
			end
			if (hit_ch1) begin
				pwm_ch1_width <= writedata[7:0];
			end
		end
	end

	// Read mux; status word shows the live counter and the dither phase
	always_comb begin
		next_readdata = 32'h0000_0000;
		if (hit_control) begin
			next_readdata[`HPW_CTL_USED_W-1:0] = pwm_control;
		end else if (hit_ch0) begin
			next_readdata[7:0] = pwm_ch0_width;
		end else if (hit_ch1) begin
			next_readdata[7:0] = pwm_ch1_width;
		end else if (hit_status) begin
			next_readdata[7:0] = count;
			next_readdata[8]   = dither_phase;
		end
	end

	// Read data latched while waitrequest is high, stable at acceptance
	// Latching in the wait cycle keeps readdata off the decode logic
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			readdata <= 32'h0000_0000;
		end else if (clk_en && read && !accept) begin
			readdata <= next_readdata;
		end
	end

	// ------------------------------------------------------------------
	// Resolution decode
	// ------------------------------------------------------------------

	// Reserved code 11 falls back to 8-bit so the counter never runs away
	always_comb begin
		case (pwm_control.resolution_mode)
			`HPW_MODE_8BIT: resolution = HPW_RES_8;
			`HPW_MODE_7BIT: resolution = HPW_RES_7;
			`HPW_MODE_6BIT: resolution = HPW_RES_6;
			default:        resolution = HPW_RES_8;
		endcase
	end

	// Wrap point sets the period: 256, 128 or 64 source clocks
	always_comb begin
		case (resolution)
			HPW_RES_8: wrap_value = `HPW_WRAP_8BIT;
			HPW_RES_7: wrap_value = `HPW_WRAP_7BIT;
			HPW_RES_6: wrap_value = `HPW_WRAP_6BIT;
			default:   wrap_value = `HPW_WRAP_8BIT;
		endcase
	end

	// ------------------------------------------------------------------
	// Shared up counter
	// ------------------------------------------------------------------

	// Last count of the period in the current resolution
	assign period_end = (count == wrap_value);

	// Next count wraps at the period end; stopped means cleared
	always_comb begin
		if (!pwm_control.counter_run) begin
			next_count = 8'h00;
		end else if (period_end) begin
			next_count = 8'h00;
		end else begin
			next_count = count + 8'h01;
		end
	end

	// Counter register; clock enable low freezes it mid-period
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= 8'h00;
		end else if (clk_en) begin
			count <= next_count;
		end
	end

	// Dither phase alternates each period in every mode, restarts when stopped
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dither_phase <= 1'b0;
		end else if (clk_en) begin
			if (!pwm_control.counter_run) begin
				dither_phase <= 1'b0;
			end else if (period_end) begin
				dither_phase <= ~dither_phase;
			end
		end
	end

	// ------------------------------------------------------------------
	// Width shadows
	// ------------------------------------------------------------------

	// Shadows reload only at a period boundary, so no period is cut mid-way;
	// while stopped they track the registers so the first period is current;
	// clock enable low stalls them too, so a frozen period stays whole
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			shadow_ch0 <= `HPW_RST_WIDTH;
			shadow_ch1 <= `HPW_RST_WIDTH;
		end else if (clk_en && (!pwm_control.counter_run || period_end)) begin
			shadow_ch0 <= pwm_ch0_width;
			shadow_ch1 <= pwm_ch1_width;
		end
	end

	// ------------------------------------------------------------------
	// Width to clocks, per resolution
	// ------------------------------------------------------------------

	// Splits a width value into whole clocks and a half-clock extension;
	// two half steps in one 6-bit period merge into one whole clock
	function automatic hpw_width_t width_of(
		input hpw_res_t   res,
		input logic [7:0] data,
		input logic       phase
	);
		hpw_width_t w;
		logic [1:0] halves;
		w      = '0;
		halves = 2'h0;
		// Halves merge so the pin never needs a quarter-clock edge
		case (res)
			HPW_RES_8: begin
				w.whole_clocks = {1'b0, data};
				w.half_ext     = 1'b0;
			end
			HPW_RES_7: begin
				w.whole_clocks = {2'h0, data[7:1]};
				w.half_ext     = data[0];
			end
			HPW_RES_6: begin
				halves         = {1'b0, data[1]} + {1'b0, data[0] & phase};
				w.whole_clocks = {3'h0, data[7:2]} + {8'h00, halves[1]};
				w.half_ext     = halves[0];
			end
			default: begin
				w.whole_clocks = {1'b0, data};
				w.half_ext     = 1'b0;
			end
		endcase
		return w;
	endfunction : width_of

	// Both channels use the one shared resolution
	assign width_ch0 = width_of(resolution, shadow_ch0, dither_phase);
	assign width_ch1 = width_of(resolution, shadow_ch1, dither_phase);

	// ------------------------------------------------------------------
	// Output channels
	// ------------------------------------------------------------------

	// Channel 0
	hpw_channel u_ch0 (
		.sys_clk       (sys_clk),
		.rst_n         (rst_n),
		.clk_en        (clk_en),
		.counter_run   (pwm_control.counter_run),
		.count         (count),
		.output_enable (pwm_control.ch0_output_enable),
		.width         (width_ch0),
		.pulse_out     (pulse_out_ch0)
	);

	// Channel 1
	hpw_channel u_ch1 (
		.sys_clk       (sys_clk),
		.rst_n         (rst_n),
		.clk_en        (clk_en),
		.counter_run   (pwm_control.counter_run),
		.count         (count),
		.output_enable (pwm_control.ch1_output_enable),
		.width         (width_ch1),
		.pulse_out     (pulse_out_ch1)
	);

endmodule : hpw_top

// [sim/hpw_top_asserts.sv]
// Port-level assertions of the fast pulse block
`timescale 1ns/1ps
module hpw_top_asserts (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	// Register bus
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [3:0]  byteenable,
	input  wire logic [31:0] writedata,
	input  wire logic [31:0] readdata,
	input  wire logic        waitrequest,
	// Pulse pins
	input  wire logic        pulse_out_ch0,
	input  wire logic        pulse_out_ch1
);
	logic [4:0] ctl;
	logic [2:0] stopped;
	wire        rd_ok  = read && !waitrequest;
	wire        mapped = address inside {8'h30, 8'h34, 8'h38, 8'h3c};

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// Shadow of control, so pin checks know run state and enables
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			ctl <= 5'h00;
		else if (write && !waitrequest && address == 8'h30 && byteenable[0])
			ctl <= writedata[4:0];
	end

	// Cycles spent stopped, saturating; a clear counter needs a settled stop
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			stopped <= 3'h0;
		else if (ctl[2])
			stopped <= 3'h0;
		else if (stopped != 3'h7)
			stopped <= stopped + 3'h1;
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	a_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("access not accepted after one wait");
	a_idle_ready: assert property (!(read || write) |-> !waitrequest)
		else $error("waitrequest high while idle");
	a_ack_single: assert property ((read || write) && !waitrequest |=> waitrequest || !(read || write))
		else $error("two accepts in a row");
	a_stop_high: assert property (!ctl[2] [*3] |-> pulse_out_ch0 && pulse_out_ch1)
		else $error("pins not high while stopped");
	a_ch0_off: assert property (!ctl[3] [*3] |-> pulse_out_ch0)
		else $error("disabled channel 0 pin not high");
	a_ch1_off: assert property (!ctl[4] [*3] |-> pulse_out_ch1)
		else $error("disabled channel 1 pin not high");
	a_stat_clear: assert property (rd_ok && address == 8'h3c && stopped == 3'h7 |-> readdata[7:0] == 8'h00)
		else $error("counter not cleared while stopped");
	a_unmapped_zero: assert property (rd_ok && !mapped |-> readdata == 32'h0)
		else $error("unmapped read not zero");
	a_ctl_back: assert property (rd_ok && address == 8'h30 |-> readdata == {27'h0, ctl})
		else $error("control readback wrong");
	a_period_full: assert property ($fell(pulse_out_ch0) && ctl[1:0] == 2'h0 && ctl[3:2] == 2'h3
		|-> ##256 ($fell(pulse_out_ch0) || ctl[3:2] != 2'h3 || ctl[1:0] != 2'h0))
		else $error("8-bit period not 256 clocks");
endmodule : hpw_top_asserts

// [sim/testbench.sv]
// Self-checking testbench of the fast pulse block
`timescale 1ns/1ps
module testbench;
	logic        sys_clk, rst_n, clk_en, read, write, waitrequest;
	logic [7:0]  address;
	logic [3:0]  byteenable;
	logic [31:0] writedata, readdata, rv, rv1;
	// Pins taken as already handed over to the pulse function
	logic        pulse_out_ch0, pulse_out_ch1;
	int          error_cnt, compares, l0, l1;

	hpw_top hpw_top_inst (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
		.address(address), .read(read), .write(write), .byteenable(byteenable),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.pulse_out_ch0(pulse_out_ch0), .pulse_out_ch1(pulse_out_ch1));

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic end_of_test();
		$display("error_cnt %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// One Avalon access; request held until waitrequest seen low at a rising edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		logic w;
		int   n;
		@(posedge sys_clk);
		read       <= !wr;
		write      <= wr;
		address    <= a;
		writedata  <= d;
		byteenable <= be;
		w = 1'b1;
		for (n = 0; n < 20 && w !== 1'b0; n++) begin
			@(posedge sys_clk);
			w = waitrequest;
			q = readdata;
		end
		if (w !== 1'b0) begin
			error_cnt++;
			end_of_test();
		end
		read  <= 1'b0;
		write <= 1'b0;
	endtask : bus

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 4'hf, rv);
		check(rv, exp);
	endtask : rdchk

	// Low time in half clocks, sampled just after every clock edge
	task automatic measure(input int n);
		l0 = 0;
		l1 = 0;
		repeat (2 * n) begin
			@(sys_clk);
			#1;
			l0 += int'(pulse_out_ch0 === 1'b0);
			l1 += int'(pulse_out_ch1 === 1'b0);
		end
	endtask : measure

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic test_reset();
		check({30'h0, pulse_out_ch1, pulse_out_ch0}, 32'h3);
		rdchk(8'h30, 32'h0);
		rdchk(8'h34, 32'h10);
		rdchk(8'h38, 32'h10);
		rdchk(8'h3c, 32'h0);
	endtask : test_reset

	task automatic test_regs();
		bus(1'b1, 8'h34, 32'ha5, 4'hf, rv);
		bus(1'b1, 8'h38, 32'h5a, 4'hf, rv);
		bus(1'b1, 8'h34, 32'h33, 4'he, rv);
		bus(1'b1, 8'h40, 32'h77, 4'hf, rv);
		bus(1'b1, 8'h30, 32'h19, 4'hf, rv);
		rdchk(8'h34, 32'ha5);
		rdchk(8'h38, 32'h5a);
		rdchk(8'h40, 32'h0);
		rdchk(8'h31, 32'h0);
		rdchk(8'h30, 32'h19);
		check({30'h0, pulse_out_ch1, pulse_out_ch0}, 32'h3);
	endtask : test_regs

	// Channel 0 alone in 8-bit mode, live width change, then stop
	task automatic test_run_stop();
		bus(1'b1, 8'h30, 32'h08, 4'hf, rv);
		bus(1'b1, 8'h34, 32'h40, 4'hf, rv);
		bus(1'b1, 8'h30, 32'h0c, 4'hf, rv);
		bus(1'b0, 8'h3c, 32'h0, 4'hf, rv1);
		bus(1'b0, 8'h3c, 32'h0, 4'hf, rv);
		check({24'h0, rv[7:0] - rv1[7:0]}, 32'h3);
		measure(256);
		check(32'(l0), 32'd128);
		check(32'(l1), 32'd0);
		bus(1'b1, 8'h34, 32'h20, 4'hf, rv);
		repeat (256) @(posedge sys_clk);
		measure(256);
		check(32'(l0), 32'd64);
		bus(1'b1, 8'h30, 32'h08, 4'hf, rv);
		rdchk(8'h3c, 32'h0);
		check({31'h0, pulse_out_ch0}, 32'h1);
		repeat (260) @(posedge sys_clk);
	endtask : test_run_stop

	// Every mode, both channels, a 256-clock window each
	task automatic test_modes();
		logic [1:0] md [3] = '{2'h0, 2'h1, 2'h2};
		logic [7:0] d0 [3] = '{8'h10, 8'h21, 8'h13};
		logic [7:0] d1 [3] = '{8'hf0, 8'he6, 8'h10};
		int         e0 [3] = '{32, 66, 38};
		int         e1 [3] = '{480, 460, 32};
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, 8'h30, {27'h0, 3'h6, md[i]}, 4'hf, rv);
			bus(1'b1, 8'h34, {24'h0, d0[i]}, 4'hf, rv);
			bus(1'b1, 8'h38, {24'h0, d1[i]}, 4'hf, rv);
			bus(1'b1, 8'h30, {27'h0, 3'h7, md[i]}, 4'hf, rv);
			repeat (300) @(posedge sys_clk);
			measure(256);
			check(32'(l0), 32'(e0[i]));
			check(32'(l1), 32'(e1[i]));
			bus(1'b1, 8'h30, {27'h0, 3'h6, md[i]}, 4'hf, rv);
		end
		bus(1'b1, 8'h30, 32'h0, 4'hf, rv);
	endtask : test_modes

	// Clock enable freeze, then an asynchronous reset, both while running
	task automatic test_freeze_reset();
		bus(1'b1, 8'h30, 32'h10, 4'hf, rv);
		bus(1'b1, 8'h38, 32'h80, 4'hf, rv);
		bus(1'b1, 8'h30, 32'h14, 4'hf, rv);
		repeat (20) @(posedge sys_clk);
		bus(1'b0, 8'h3c, 32'h0, 4'hf, rv1);
		@(posedge sys_clk);
		clk_en <= 1'b0;
		repeat (10) @(posedge sys_clk);
		clk_en <= 1'b1;
		bus(1'b0, 8'h3c, 32'h0, 4'hf, rv);
		check({24'h0, rv[7:0] - rv1[7:0]}, 32'h4);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		@(posedge sys_clk);
		check({30'h0, pulse_out_ch1, pulse_out_ch0}, 32'h3);
		rst_n <= 1'b1;
		rdchk(8'h30, 32'h0);
		rdchk(8'h38, 32'h10);
		rdchk(8'h3c, 32'h0);
	endtask : test_freeze_reset

	// Free-running clock, 4 ns period
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// Main sequence
	initial begin
		rst_n      = 1'b0;
		clk_en     = 1'b1;
		read       = 1'b0;
		write      = 1'b0;
		address    = 8'h00;
		byteenable = 4'h0;
		writedata  = 32'h0;
		error_cnt  = 0;
		compares   = 0;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		test_reset();
		test_regs();
		test_run_stop();
		test_modes();
		test_freeze_reset();
		end_of_test();
	end
endmodule : testbench

bind hpw_top hpw_top_asserts hpw_top_asserts_inst (.sys_clk(sys_clk), .rst_n(rst_n),
	.clk_en(clk_en), .address(address), .read(read), .write(write),
	.byteenable(byteenable), .writedata(writedata), .readdata(readdata),
	.waitrequest(waitrequest), .pulse_out_ch0(pulse_out_ch0), .pulse_out_ch1(pulse_out_ch1));
